// ---- brk_cfg.svh ----
// register map, field positions and reset values of the break comparator
`ifndef BRK_CFG_SVH
`define BRK_CFG_SVH
`define OFS_COND        4'h0
`define OFS_STAT        4'h4
`define OFS_ADDR        4'h8
`define OFS_DATA        4'hC
`define COND_RESET      8'h80
`define STAT_RSVD       6'h3F
`define ADDR_RESET      16'hFFFF
`define BIT_POSTRET     7
`define BIT_FLAG        7
`define BIT_IE          6
`define CSEL_HI         6
`define CSEL_LO         5
`define AMSK_HI         4
`define AMSK_LO         2
`define DSEL_HI         1
`define DSEL_LO         0
`define SPEC_A_LO       16'hFF96
`define SPEC_A_HI       16'hFF97
`define SPEC_B_LO       16'hFFB8
`define SPEC_B_HI       16'hFFBB
`endif

// ---- brk_pkg.sv ----
// types shared by the break comparator
`default_nettype none
package brk_pkg;
  typedef enum logic [1:0] {
    CYC_FETCH = 2'h0,
    CYC_READ  = 2'h1,
    CYC_WRITE = 2'h2,
    CYC_RW    = 2'h3
  } cyc_sel_t;
  typedef enum logic [1:0] {
    SPACE_MEM   = 2'h0,
    SPACE_IO8   = 2'h1,
    SPACE_IO16  = 2'h2
  } space_t;
  // one observed cpu bus cycle
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        rd;
    logic        wr;
    logic        word;
    space_t      space;
    logic [15:0] addr;
    logic [15:0] data;
  } cpu_cycle_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage : brk_pkg
`default_nettype wire

// ---- address_break_comparator.sv ----
// address break comparator with avalon-mm register slave
//
// Chosen here: the register offsets and the Avalon-MM register port.
`include "brk_cfg.svh"
`default_nettype none
module address_break_comparator (
  input  wire logic            CORE_CLK,
  input  wire logic            RST_N,
  input  wire logic            CLK_EN,
  input  wire logic            MODULE_STANDBY,
  input  wire brk_pkg::cpu_cycle_t CPU_CYCLE,
  input  wire logic [3:0]      AVS_ADDRESS,
  input  wire logic            AVS_READ,
  input  wire logic            AVS_WRITE,
  input  wire logic [31:0]     AVS_WRITEDATA,
  input  wire logic [3:0]      AVS_BYTEENABLE,
  output logic [31:0]          AVS_READDATA,
  output logic                 AVS_WAITREQUEST,
  output logic [1:0]           AVS_RESPONSE,
  output logic                 BREAK_IRQ,
  output logic                 POST_RETURN_HOLD
);
  import brk_pkg::*;

  logic [7:0]  cond_reg;
  logic        flag_reg;
  logic        ie_reg;
  logic        flag_seen_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  bus_state_t  bus_reg;
  logic        run;
  logic        acc;
  logic        hit;
  logic        addr_ok;
  logic        type_ok;
  logic        data_ok;
  logic [15:0] amask;
  logic        upper_lane;
  logic [7:0]  lane_val;
  logic        spec_io;
  logic [7:0]  stat_val;
  logic [31:0] rd_val;
  logic        wr_stat;
  logic        wr_cond;
  logic        wr_addr;
  logic        wr_data;
  logic        rd_stat;
  logic        io16_byte;

  // standby stops register and flag updates, contents kept; bus port and outputs keep running
  // standby freeze
  assign run = CLK_EN && !MODULE_STANDBY;

  // a request is accepted one edge after it appears
  assign acc = (AVS_READ || AVS_WRITE) && bus_reg == BUS_ACK;
  assign wr_stat = acc && AVS_WRITE && AVS_ADDRESS == `OFS_STAT
                   && AVS_BYTEENABLE[0];

  // run folded into the strobes so standby drops register writes
  assign wr_cond = run && acc && AVS_WRITE && AVS_ADDRESS == `OFS_COND
                   && AVS_BYTEENABLE[0];
  assign wr_addr = run && acc && AVS_WRITE && AVS_ADDRESS == `OFS_ADDR;
  assign wr_data = run && acc && AVS_WRITE && AVS_ADDRESS == `OFS_DATA;
  assign rd_stat = acc && AVS_READ && AVS_ADDRESS == `OFS_STAT;

  always_comb begin
    case (cyc_sel_t'(cond_reg[`CSEL_HI:`CSEL_LO]))
      CYC_FETCH: type_ok = CPU_CYCLE.fetch;
      CYC_READ:  type_ok = CPU_CYCLE.rd;
      CYC_WRITE: type_ok = CPU_CYCLE.wr;
      CYC_RW:    type_ok = CPU_CYCLE.rd || CPU_CYCLE.wr;
      default:   type_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (cond_reg[`AMSK_HI:`AMSK_LO])
      3'h0:    amask = 16'hFFFF;
      3'h1:    amask = 16'hFFF0;
      3'h2:    amask = 16'hFF00;
      3'h3:    amask = 16'hF000;
      // prohibited codes never match
      default: amask = 16'h0000;
    endcase
  end

  assign addr_ok = !cond_reg[`AMSK_HI]
                   && ((CPU_CYCLE.addr & amask) == (addr_reg & amask));

  assign spec_io = (CPU_CYCLE.addr >= `SPEC_A_LO
                    && CPU_CYCLE.addr <= `SPEC_A_HI)
                || (CPU_CYCLE.addr >= `SPEC_B_LO
                    && CPU_CYCLE.addr <= `SPEC_B_HI);

  always_comb begin
    case (CPU_CYCLE.space)
      SPACE_MEM:  upper_lane = !CPU_CYCLE.word || !CPU_CYCLE.addr[0];
      SPACE_IO8:  upper_lane = 1'b1;
      SPACE_IO16: upper_lane = !CPU_CYCLE.word || !CPU_CYCLE.addr[0];
      default:    upper_lane = !CPU_CYCLE.word || !CPU_CYCLE.addr[0];
    endcase
  end

  assign lane_val = upper_lane ? CPU_CYCLE.data[15:8] : CPU_CYCLE.data[7:0];

  always_comb begin
    if (cond_reg[`CSEL_HI:`CSEL_LO] == CYC_FETCH) begin
      data_ok = 1'b1;
    end else begin
      case (cond_reg[`DSEL_HI:`DSEL_LO])
        2'h0:    data_ok = 1'b1;
        2'h1:    data_ok = !upper_lane && lane_val == data_reg[7:0];
        2'h2:    data_ok = upper_lane && lane_val == data_reg[15:8];
        2'h3:    data_ok = CPU_CYCLE.word && !CPU_CYCLE.addr[0]
                           && CPU_CYCLE.data == data_reg;
        default: data_ok = 1'b0;
      endcase
    end
  end

  // byte access to ordinary 16-bit io does not occur
  // ordinary 16-bit io word only
  assign io16_byte = CPU_CYCLE.space == SPACE_IO16 && !spec_io
                     && !CPU_CYCLE.word;

  assign hit = CPU_CYCLE.valid && type_ok && addr_ok && data_ok
               && !io16_byte;

  assign stat_val = {flag_reg, ie_reg, `STAT_RSVD};

  always_comb begin
    rd_val = 32'h0000_0000;
    case (AVS_ADDRESS)
      `OFS_COND: rd_val = {24'h000000, cond_reg};
      `OFS_STAT: rd_val = {24'h000000, stat_val};
      `OFS_ADDR: rd_val = {16'h0000, addr_reg};
      `OFS_DATA: rd_val = {16'h0000, data_reg};
      default:   rd_val = 32'h0000_0000;
    endcase
  end

  // bus handshake: waitrequest low for one cycle per request
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_reg         <= BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else if (CLK_EN) begin
      case (bus_reg)
        BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_reg         <= BUS_ACK;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_reg         <= BUS_DONE;
          AVS_WAITREQUEST <= 1'b1;
        end
        BUS_DONE: bus_reg <= BUS_IDLE;
        default: begin
          bus_reg         <= BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
      AVS_RESPONSE <= 2'h0;
    end else if (CLK_EN) begin
      if ((AVS_READ || AVS_WRITE) && bus_reg == BUS_IDLE) begin
        AVS_READDATA <= AVS_READ ? rd_val : 32'h0000_0000;
        // unmapped offsets answer with a slave error
        AVS_RESPONSE <= (AVS_ADDRESS[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cond_reg <= `COND_RESET;
    end else if (wr_cond) begin
      cond_reg <= AVS_WRITEDATA[7:0];
    end
  end

  byte_wr_reg #(
    .NBYTES    (2),
    .HAS_RESET (1'b1),
    .RESET_VAL (`ADDR_RESET)
  ) addr_store (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .en    (wr_addr),
    .be    (AVS_BYTEENABLE[1:0]),
    .wdata (AVS_WRITEDATA[15:0]),
    .q     (addr_reg)
  );

  // data register has no reset
  // contents survive every reset, undefined at power-up
  byte_wr_reg #(
    .NBYTES    (2),
    .HAS_RESET (1'b0)
  ) data_store (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .en    (wr_data),
    .be    (AVS_BYTEENABLE[1:0]),
    .wdata (AVS_WRITEDATA[15:0]),
    .q     (data_reg)
  );

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ie_reg <= 1'b0;
    end else if (run && wr_stat) begin
      ie_reg <= AVS_WRITEDATA[`BIT_IE];
    end
  end

  // remembers that software has read the flag as one
  // read-one then write-zero
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_seen_reg <= 1'b0;
    end else if (run) begin
      if (rd_stat && flag_reg) begin
        flag_seen_reg <= 1'b1;
      end else if (wr_stat || !flag_reg) begin
        flag_seen_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
    end else if (run) begin
      if (hit) begin
        flag_reg <= 1'b1;
      end else if (wr_stat && flag_seen_reg && !AVS_WRITEDATA[`BIT_FLAG]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // no cpu mask term here; the core defers entry to instruction end
  // not gated by global mask
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BREAK_IRQ        <= 1'b0;
      POST_RETURN_HOLD <= 1'b0;
    end else if (CLK_EN) begin
      BREAK_IRQ        <= flag_reg && ie_reg;
      POST_RETURN_HOLD <= !cond_reg[`BIT_POSTRET];
    end
  end

endmodule // address_break_comparator

// byte-writable register; one instance per 16-bit register
module byte_wr_reg #(
  parameter int unsigned           NBYTES    = 2,
  parameter bit                    HAS_RESET = 1'b1,
  parameter logic [NBYTES*8-1:0]   RESET_VAL = '0
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                en,
  input  wire logic [NBYTES-1:0]   be,
  input  wire logic [NBYTES*8-1:0] wdata,
  output logic [NBYTES*8-1:0]      q
);

  // each byte lane loads only when its enable is set
  if (HAS_RESET) begin : g_rst
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        q <= RESET_VAL;
      end else if (en) begin
        for (int i = 0; i < NBYTES; i++) begin
          if (be[i]) begin
            q[i*8 +: 8] <= wdata[i*8 +: 8];
          end
        end
      end
    end
  end else begin : g_keep
    // no reset: rst_n left unused on purpose
    always_ff @(posedge clk) begin
      if (en) begin
        for (int i = 0; i < NBYTES; i++) begin
          if (be[i]) begin
            q[i*8 +: 8] <= wdata[i*8 +: 8];
          end
        end
      end
    end
  end

endmodule // byte_wr_reg
`default_nettype wire

// ---- address_break_comparator_chk.sv ----
// port assertions for the break comparator
`include "brk_cfg.svh"
`default_nettype none
module address_break_comparator_chk (
  input wire logic                CORE_CLK,
  input wire logic                RST_N,
  input wire logic                MODULE_STANDBY,
  input wire brk_pkg::cpu_cycle_t CPU_CYCLE,
  input wire logic [3:0]          AVS_ADDRESS,
  input wire logic                AVS_READ,
  input wire logic                AVS_WRITE,
  input wire logic [31:0]         AVS_WRITEDATA,
  input wire logic [3:0]          AVS_BYTEENABLE,
  input wire logic [31:0]         AVS_READDATA,
  input wire logic                AVS_WAITREQUEST,
  input wire logic [1:0]          AVS_RESPONSE,
  input wire logic                BREAK_IRQ,
  input wire logic                POST_RETURN_HOLD
);
  import brk_pkg::*;
  logic acc, stw, cdw;
  assign acc = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign stw = acc && AVS_WRITE && AVS_ADDRESS == `OFS_STAT;
  // standby writes never reach the condition bits
  assign cdw = acc && AVS_WRITE && AVS_ADDRESS == `OFS_COND
    && AVS_BYTEENABLE[0] && !MODULE_STANDBY;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low two cycles");
  a_wait_cause: assert property
    (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");
  a_resp_code: assert property (acc |-> AVS_RESPONSE ==
    (AVS_ADDRESS[1:0] != 2'h0 ? 2'h2 : 2'h0))
    else $error("wrong response code");
  a_stat_rsvd: assert property (acc && AVS_READ &&
    AVS_ADDRESS == `OFS_STAT |-> AVS_READDATA[5:0] == 6'h3F)
    else $error("reserved status bits not ones");
  a_irq_fall: assert property ($fell(BREAK_IRQ) |-> $past(stw, 2))
    else $error("request dropped without status write");
  a_irq_cause: assert property ($rose(BREAK_IRQ) |->
    $past(stw, 2) || $past(CPU_CYCLE.valid, 2))
    else $error("request raised without cause");
  a_hold_set: assert property (cdw |=> ##1
    POST_RETURN_HOLD == !$past(AVS_WRITEDATA[7], 2))
    else $error("hold output not inverse of bit 7");
  a_hold_keep: assert property (!$stable(POST_RETURN_HOLD) |->
    $past(cdw) || $past(cdw, 2))
    else $error("hold output moved on its own");
endmodule // address_break_comparator_chk
bind address_break_comparator address_break_comparator_chk chk (
  .CORE_CLK, .RST_N, .MODULE_STANDBY, .CPU_CYCLE, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
  .AVS_WAITREQUEST, .AVS_RESPONSE, .BREAK_IRQ, .POST_RETURN_HOLD);
`default_nettype wire

// ---- cpu_bus_model.sv ----
// behavioural cpu core that puts bus cycles on the observed bus
`default_nettype none
module cpu_bus_model (
  input  wire logic               CORE_CLK,
  output var brk_pkg::cpu_cycle_t CPU_CYCLE
);
  import brk_pkg::*;
  initial CPU_CYCLE = '0;
  task automatic one(input cpu_cycle_t c);
    @(posedge CORE_CLK);
    CPU_CYCLE <= c;
    @(posedge CORE_CLK);
    // idle bus shows an inverted pattern, never the stale cycle
    CPU_CYCLE <= {1'b0, ~c[37:0]};
  endtask
  task automatic issue(input cpu_cycle_t c);
    cpu_cycle_t b;
    b = c;
    if (c.space == SPACE_IO8 && c.word) begin
      b.word = 1'b0;
      one(b);
      b.addr = c.addr + 16'h1;
      one(b);
    end else begin
      one(c);
    end
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// ---- address_break_comparator_tb.sv ----
// self-checking bench for the break comparator
`include "brk_cfg.svh"
`default_nettype none
module address_break_comparator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import brk_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        MODULE_STANDBY = 1'b0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA, rdat;
  logic [1:0]  AVS_RESPONSE, resp;
  logic        AVS_WAITREQUEST, BREAK_IRQ, POST_RETURN_HOLD;
  wire cpu_cycle_t CPU_CYCLE;
  int          error_cnt = 0;
  int          compares = 0;
  localparam cpu_cycle_t HIT = {1'b1, 4'h9, 2'h0, 16'h1234, 16'h0};
  always #20 CORE_CLK = ~CORE_CLK;
  cpu_bus_model cpu (.CORE_CLK, .CPU_CYCLE);
  address_break_comparator dut (.CORE_CLK, .RST_N, .CLK_EN(1'b1),
    .MODULE_STANDBY, .CPU_CYCLE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .AVS_RESPONSE, .BREAK_IRQ, .POST_RETURN_HOLD);
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic xfer(input logic r, input logic [3:0] a,
      input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    AVS_READ <= r;
    AVS_WRITE <= !r;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge CORE_CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (n == 20) begin
      error_cnt++;
      give_verdict();
    end
    rdat = AVS_READDATA;
    resp = AVS_RESPONSE;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    xfer(1'b0, a, d);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] x);
    xfer(1'b1, a, 32'h0);
    chk(rdat, x);
  endtask
  // one cpu access against one condition (two bus cycles for an 8-bit io word), then flag read and clear
  task automatic tc(input logic [7:0] c, input logic [3:0] k,
      input logic [1:0] sp, input logic [15:0] ca, cd, input logic e);
    wr(`OFS_COND, {24'h0, c});
    cpu.issue({1'b1, k, sp, ca, cd});
    repeat (3) @(posedge CORE_CLK);
    rchk(`OFS_STAT, e ? 32'hFF : 32'h7F);
    chk(BREAK_IRQ, e);
    wr(`OFS_STAT, 32'h40);
  endtask
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    chk(POST_RETURN_HOLD, 1'b0);
    rchk(`OFS_COND, 32'h80);
    rchk(`OFS_STAT, 32'h3F);
    rchk(`OFS_ADDR, 32'hFFFF);
    xfer(1'b1, 4'h5, 32'h0);
    chk(resp, 2'h2);
    AVS_BYTEENABLE <= 4'h1;
    wr(`OFS_ADDR, 32'h1234_5600);
    AVS_BYTEENABLE <= 4'hF;
    rchk(`OFS_ADDR, 32'hFF00);
    wr(`OFS_DATA, 32'hAA55);
    RST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rchk(`OFS_DATA, 32'hAA55);
    rchk(`OFS_ADDR, 32'hFFFF);
    wr(`OFS_COND, 32'h0);
    repeat (2) @(posedge CORE_CLK);
    chk(POST_RETURN_HOLD, 1'b1);
    wr(`OFS_STAT, 32'hFF);
    rchk(`OFS_STAT, 32'h7F);
    $display("test registers done");
    wr(`OFS_ADDR, 32'h1234);
    tc(8'h80, 4'h9, 2'h0, 16'h1234, 16'h0, 1'b1);
    tc(8'h80, 4'h9, 2'h0, 16'h1235, 16'h0, 1'b0);
    tc(8'h84, 4'h9, 2'h0, 16'h123F, 16'h0, 1'b1);
    tc(8'h88, 4'h9, 2'h0, 16'h12C0, 16'h0, 1'b1);
    tc(8'h8C, 4'h9, 2'h0, 16'h1FFF, 16'h0, 1'b1);
    tc(8'h8C, 4'h9, 2'h0, 16'h2234, 16'h0, 1'b0);
    tc(8'h90, 4'h9, 2'h0, 16'h1234, 16'h0, 1'b0);
    tc(8'h80, 4'h5, 2'h0, 16'h1234, 16'h0, 1'b0);
    tc(8'hA0, 4'h5, 2'h0, 16'h1234, 16'h0, 1'b1);
    tc(8'hA0, 4'h3, 2'h0, 16'h1234, 16'h0, 1'b0);
    tc(8'hC0, 4'h3, 2'h0, 16'h1234, 16'h0, 1'b1);
    tc(8'hE0, 4'h3, 2'h0, 16'h1234, 16'h0, 1'b1);
    tc(8'hA3, 4'h5, 2'h0, 16'h1234, 16'hAA55, 1'b1);
    tc(8'hA3, 4'h5, 2'h0, 16'h1234, 16'hAA54, 1'b0);
    wr(`OFS_ADDR, 32'h1235);
    tc(8'hA1, 4'h5, 2'h0, 16'h1235, 16'h0055, 1'b1);
    tc(8'hA2, 4'h4, 2'h0, 16'h1235, 16'hAA00, 1'b1);
    tc(8'hA2, 4'h5, 2'h0, 16'h1235, 16'hAA00, 1'b0);
    wr(`OFS_ADDR, 32'hFF11);
    tc(8'hA2, 4'h5, 2'h1, 16'hFF10, 16'hAA00, 1'b1);
    wr(`OFS_ADDR, 32'hFF97);
    tc(8'hA2, 4'h4, 2'h2, 16'hFF97, 16'hAA00, 1'b1);
    wr(`OFS_ADDR, 32'hFF41);
    tc(8'hA2, 4'h4, 2'h2, 16'hFF41, 16'hAA00, 1'b0);
    $display("test conditions done");
    wr(`OFS_COND, 32'h80);
    wr(`OFS_ADDR, 32'h1234);
    cpu.issue(HIT);
    wr(`OFS_STAT, 32'h40);
    rchk(`OFS_STAT, 32'hFF);
    wr(`OFS_STAT, 32'hC0);
    wr(`OFS_STAT, 32'h40);
    rchk(`OFS_STAT, 32'hFF);
    chk(BREAK_IRQ, 1'b1);
    // clear lands on the same edge as a fresh match
    fork
      wr(`OFS_STAT, 32'h40);
      begin
        @(posedge CORE_CLK);
        cpu.issue(HIT);
      end
    join
    rchk(`OFS_STAT, 32'hFF);
    wr(`OFS_STAT, 32'h0);
    rchk(`OFS_STAT, 32'h3F);
    chk(BREAK_IRQ, 1'b0);
    $display("test clearing done");
    MODULE_STANDBY <= 1'b1;
    wr(`OFS_COND, 32'h0);
    rchk(`OFS_COND, 32'h80);
    cpu.issue(HIT);
    repeat (3) @(posedge CORE_CLK);
    rchk(`OFS_STAT, 32'h3F);
    MODULE_STANDBY <= 1'b0;
    $display("test standby done");
    give_verdict();
  end
endmodule // address_break_comparator_tb
`default_nettype wire
